// *** logic/egc_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the gearing block.
`ifndef EGC_DEFS_SVH
`define EGC_DEFS_SVH
`define EGC_OFF_CTRL 8'h00
`define EGC_OFF_GEAR_NUM 8'h04
`define EGC_OFF_GEAR_DEN 8'h08
`define EGC_OFF_RES 8'h0c
`define EGC_OFF_ACC_CAP 8'h10
`define EGC_OFF_DEC_CAP 8'h14
`define EGC_OFF_SPD_CAP 8'h18
`define EGC_OFF_FERR_TH 8'h1c
`define EGC_OFF_POS_SPD 8'h20
`define EGC_OFF_NEG_SPD 8'h24
`define EGC_OFF_OVS_TH 8'h28
`define EGC_OFF_BOUND_LO 8'h2c
`define EGC_OFF_BOUND_HI 8'h30
`define EGC_OFF_POS_CUR 8'h34
`define EGC_OFF_NEG_CUR 8'h38
`define EGC_OFF_CUR_REQ 8'h3c
`define EGC_OFF_GEAR_POS 8'h40
`define EGC_OFF_MOTOR_POS 8'h44
`define EGC_OFF_POS_ERR 8'h48
`define EGC_OFF_VEL 8'h4c
`define EGC_OFF_STATUS 8'h50
`define EGC_OFF_MASK 8'h54
`define EGC_OFF_WARN 8'h58
`define EGC_OFF_CUR_OUT 8'h5c
`define EGC_CTRL_SRC_LSB 0
`define EGC_CTRL_MODE_LSB 4
`define EGC_CTRL_PORT_LSB 8
`define EGC_CTRL_SYNC_BIT 12
`define EGC_SRC_GEARING 4'h2
`define EGC_MODE_POSITION 4'h2
`define EGC_PORT_QUAD 4'h3
`define EGC_PORT_PULSE 4'h4
`define EGC_PORT_UPDN 4'h5
`define EGC_ST_FERR 0
`define EGC_ST_OVS 1
`define EGC_ST_SOFT_LO 2
`define EGC_ST_SOFT_HI 3
`define EGC_WARN_SOFT_LO 12'h107
`define EGC_RST_RES 32'h0000_1000
`define EGC_RST_CAP 32'h0000_0100
`define EGC_RST_BIG 32'h7fff_ffff
`define EGC_UPDATE_NS 1000
`define EGC_CLK_NS 8
`define EGC_UPDATE_CYC ((`EGC_UPDATE_NS + `EGC_CLK_NS - 1) / `EGC_CLK_NS)
`endif

// *** logic/egc_pkg.sv ***
// Types shared by the gearing block.
package egc_pkg;
	typedef enum logic [1:0] {
		EGC_IDLE = 2'b00,
		EGC_RAMP = 2'b01,
		EGC_LOCK = 2'b10
	} egc_state_e;
	typedef struct packed {
		logic src_a;
		logic src_b;
	} egc_pins_s;
endpackage

// *** logic/egc_gearing.sv ***
// Electronic gearing command block with limits and Wishbone registers.
// Operation
// - Drive only with gearing source and position mode.
// - Only port modes 3,4,5 feed counter.
// - Code selects quadrature, pulse/direction or up/down.
// - Resolution counts post-quadrature edges per revolution.
// - Gear ratio scales motor revolutions per input.
// - Gearing position spans 2^32 per revolution, wraps.
// - Gearing position ignores gear ratio.
// - Gearing accel, decel, speed caps only gearing.
// - All other limits stay enforced while gearing.
// - Sync type picks velocity or position matching.
// - Velocity matching drops counts missed during ramp.
// - Position matching recovers missed counts by overspeeding.
// - Fault when position error exceeds threshold.
// - Clamp to separate current and speed limits.
// - Over-speed fault above threshold velocity.
// - Low bound reached: stop, post warning 107.
// - High bound reached: positive position fault.
`timescale 1ns/1ps
`include "egc_defs.svh"
module egc_gearing #(
	parameter int UPDATE_CYC = `EGC_UPDATE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire egc_pkg::egc_pins_s port_pins_i,
	input wire logic [31:0] motor_feedback_i,
	output logic [31:0] motor_reference_o,
	output logic signed [31:0] current_command_o,
	output logic motor_stop_o,
	output logic irq_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl_r, num_r, den_r, res_r, acc_r, dec_r, spd_r, ferr_r;
	logic [31:0] pspd_r, nspd_r, ovs_r, blo_r, bhi_r, pcur_r, ncur_r, creq_r;
	logic [3:0] status_r, mask_r;
	logic [11:0] warn_r;
	logic [31:0] gear_pos_r, frac_r, cnt_acc_r, motor_pos_r;
	logic signed [31:0] vel_r, vel_nxt, err_r;
	logic [31:0] upd_cnt_r;
	egc_pkg::egc_state_e state_r;
	logic [2:0] a_sync_r, b_sync_r;
	logic a_q_r, b_q_r;

	wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire [7:0] off = wb_adr_i[7:0];
	wire mapped = (wb_adr_i[31:8] == 24'h0) && (off[1:0] == 2'b00) && (off <= `EGC_OFF_WARN + 8'h4);
	wire wr = wb_hit && wb_we_i && mapped;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] hi, input logic signed [31:0] lo);
		if (v > hi) begin
			return hi;
		end
		if (v < lo) begin
			return lo;
		end
		return v;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= 32'h0;
			num_r <= 32'h1;
			den_r <= 32'h1;
			res_r <= `EGC_RST_RES;
			acc_r <= `EGC_RST_CAP;
			dec_r <= `EGC_RST_CAP;
			spd_r <= `EGC_RST_CAP;
			ferr_r <= `EGC_RST_BIG;
			pspd_r <= `EGC_RST_BIG;
			nspd_r <= `EGC_RST_BIG;
			ovs_r <= `EGC_RST_BIG;
			blo_r <= 32'h8000_0000;
			bhi_r <= `EGC_RST_BIG;
			pcur_r <= `EGC_RST_BIG;
			ncur_r <= `EGC_RST_BIG;
			creq_r <= 32'h0;
			mask_r <= 4'h0;
		end else if (wr) begin
			unique case (off)
				`EGC_OFF_CTRL: ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_GEAR_NUM: num_r <= merge(num_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_GEAR_DEN: den_r <= merge(den_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_RES: res_r <= merge(res_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_ACC_CAP: acc_r <= merge(acc_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_DEC_CAP: dec_r <= merge(dec_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_SPD_CAP: spd_r <= merge(spd_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_FERR_TH: ferr_r <= merge(ferr_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_POS_SPD: pspd_r <= merge(pspd_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_NEG_SPD: nspd_r <= merge(nspd_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_OVS_TH: ovs_r <= merge(ovs_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_BOUND_LO: blo_r <= merge(blo_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_BOUND_HI: bhi_r <= merge(bhi_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_POS_CUR: pcur_r <= merge(pcur_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_NEG_CUR: ncur_r <= merge(ncur_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_CUR_REQ: creq_r <= merge(creq_r, wb_dat_i, wb_sel_i);
				`EGC_OFF_MASK: mask_r <= 4'(merge({28'h0, mask_r}, wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Command input decode
	// ----------------------------------------
	wire [3:0] src = ctrl_r[`EGC_CTRL_SRC_LSB +: 4];
	wire [3:0] opm = ctrl_r[`EGC_CTRL_MODE_LSB +: 4];
	wire [3:0] pmode = ctrl_r[`EGC_CTRL_PORT_LSB +: 4];
	wire sync_pos = ctrl_r[`EGC_CTRL_SYNC_BIT];
	wire gearing = (src == `EGC_SRC_GEARING) && (opm == `EGC_MODE_POSITION);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_sync_r <= 3'h0;
			b_sync_r <= 3'h0;
			a_q_r <= 1'b0;
			b_q_r <= 1'b0;
		end else begin
			a_sync_r <= {a_sync_r[1:0], port_pins_i.src_a};
			b_sync_r <= {b_sync_r[1:0], port_pins_i.src_b};
			if (a_sync_r[2] == a_sync_r[1]) begin
				a_q_r <= a_sync_r[2];
			end
			if (b_sync_r[2] == b_sync_r[1]) begin
				b_q_r <= b_sync_r[2];
			end
		end
	end
	wire a_new = (a_sync_r[2] == a_sync_r[1]) ? a_sync_r[2] : a_q_r;
	wire b_new = (b_sync_r[2] == b_sync_r[1]) ? b_sync_r[2] : b_q_r;
	wire a_ch = a_new ^ a_q_r;
	wire b_ch = b_new ^ b_q_r;

	logic signed [1:0] step;
	always_comb begin
		step = 2'sd0;
		unique case (pmode)
			`EGC_PORT_QUAD: begin
				if (a_ch ^ b_ch) begin
					step = ((a_ch && (a_new != b_q_r)) || (b_ch && (b_new == a_q_r))) ? 2'sd1 : -2'sd1;
				end
			end
			`EGC_PORT_PULSE: begin
				if (a_ch && a_new) begin
					step = b_q_r ? -2'sd1 : 2'sd1;
				end
			end
			`EGC_PORT_UPDN: begin
				if (a_ch && a_new && !(b_ch && b_new)) begin
					step = 2'sd1;
				end else if (b_ch && b_new && !(a_ch && a_new)) begin
					step = -2'sd1;
				end
			end
			default: step = 2'sd0;
		endcase
	end

	// ----------------------------------------
	// Gearing position and reference
	// ----------------------------------------
	// Each edge adds 2^32/resolution to the rolling input position, or subtracts it for a negative step.
	wire [31:0] pos_inc = 32'((64'h1_0000_0000) / ((res_r == 32'h0) ? 64'h1 : {32'h0, res_r}));
	wire [63:0] cmd_target = (64'(gear_pos_r) * 64'(num_r)) / ((den_r == 32'h0) ? 64'h1 : 64'(den_r));
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gear_pos_r <= 32'h0;
		end else if (step != 2'sd0) begin
			gear_pos_r <= (step > 0) ? gear_pos_r + pos_inc : gear_pos_r - pos_inc;
		end
	end

	wire upd = (upd_cnt_r == 32'(UPDATE_CYC - 1));
	always_ff @(posedge clk_i) begin
		if (rst_i || upd) begin
			upd_cnt_r <= 32'h0;
		end else begin
			upd_cnt_r <= upd_cnt_r + 32'h1;
		end
	end

	// Command motion in motor counts since the previous update.
	logic [31:0] cmd_prev_r;
	wire signed [31:0] cmd_delta = 32'(cmd_target[31:0] - cmd_prev_r);
	wire signed [31:0] track_err = 32'(cnt_acc_r - motor_pos_r);
	wire signed [31:0] v_goal = (state_r == egc_pkg::EGC_RAMP && !sync_pos) ? cmd_delta : track_err;
	wire spd_stop = motor_stop_o;

	always_comb begin
		vel_nxt = v_goal;
		if (vel_nxt > vel_r + $signed(acc_r)) begin
			vel_nxt = vel_r + $signed(acc_r);
		end
		if (vel_nxt < vel_r - $signed(dec_r)) begin
			vel_nxt = vel_r - $signed(dec_r);
		end
		vel_nxt = clamp(vel_nxt, $signed(spd_r), -$signed(spd_r));
		vel_nxt = clamp(vel_nxt, $signed(pspd_r), -$signed(nspd_r));
		if (!gearing || spd_stop) begin
			vel_nxt = 32'sd0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= egc_pkg::EGC_IDLE;
			cmd_prev_r <= 32'h0;
			cnt_acc_r <= 32'h0;
			motor_pos_r <= 32'h0;
			vel_r <= 32'sd0;
		end else if (upd) begin
			cmd_prev_r <= cmd_target[31:0];
			vel_r <= vel_nxt;
			motor_pos_r <= motor_pos_r + vel_nxt;
			unique case (state_r)
				egc_pkg::EGC_IDLE: begin
					cnt_acc_r <= motor_pos_r;
					if (gearing) begin
						state_r <= egc_pkg::EGC_RAMP;
					end
				end
				egc_pkg::EGC_RAMP: begin
					if (sync_pos) begin
						cnt_acc_r <= cnt_acc_r + cmd_delta;
					end else begin
						cnt_acc_r <= motor_pos_r + vel_nxt;
					end
					if (!gearing) begin
						state_r <= egc_pkg::EGC_IDLE;
					end else if (vel_nxt == cmd_delta) begin
						state_r <= egc_pkg::EGC_LOCK;
					end
				end
				egc_pkg::EGC_LOCK: begin
					cnt_acc_r <= cnt_acc_r + cmd_delta;
					if (!gearing) begin
						state_r <= egc_pkg::EGC_IDLE;
					end
				end
				default: state_r <= egc_pkg::EGC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Limits and outputs
	// ----------------------------------------
	wire signed [31:0] perr = 32'(motor_reference_o - motor_feedback_i);
	wire [31:0] perr_mag = perr[31] ? 32'(-perr) : perr;
	wire signed [31:0] vmag = vel_r[31] ? -vel_r : vel_r;
	wire [3:0] ev;
	assign ev[`EGC_ST_FERR] = perr_mag > ferr_r;
	assign ev[`EGC_ST_OVS] = vmag > $signed(ovs_r);
	assign ev[`EGC_ST_SOFT_LO] = gearing && ($signed(motor_pos_r) <= $signed(blo_r));
	assign ev[`EGC_ST_SOFT_HI] = gearing && ($signed(motor_pos_r) >= $signed(bhi_r));
	wire clr_st = wr && (off == `EGC_OFF_STATUS) && wb_sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= 4'h0;
			warn_r <= 12'h0;
			motor_stop_o <= 1'b0;
			irq_o <= 1'b0;
			err_r <= 32'sd0;
			motor_reference_o <= 32'h0;
			current_command_o <= 32'sd0;
		end else begin
			status_r <= (status_r & ~(clr_st ? wb_dat_i[3:0] : 4'h0)) | ev;
			irq_o <= |(((status_r & ~(clr_st ? wb_dat_i[3:0] : 4'h0)) | ev) & mask_r);
			if (ev[`EGC_ST_SOFT_LO]) begin
				warn_r <= `EGC_WARN_SOFT_LO;
			end else if (clr_st && wb_dat_i[`EGC_ST_SOFT_LO]) begin
				warn_r <= 12'h0;
			end
			motor_stop_o <= |ev[3:2] || status_r[`EGC_ST_SOFT_LO] || status_r[`EGC_ST_SOFT_HI];
			err_r <= perr;
			motor_reference_o <= motor_pos_r;
			current_command_o <= clamp($signed(creq_r), $signed(pcur_r), -$signed(ncur_r));
		end
	end

	// ----------------------------------------
	// Wishbone read and acknowledge
	// ----------------------------------------
	logic [31:0] rd;
	always_comb begin
		unique case (off)
			`EGC_OFF_CTRL: rd = ctrl_r;
			`EGC_OFF_GEAR_NUM: rd = num_r;
			`EGC_OFF_GEAR_DEN: rd = den_r;
			`EGC_OFF_RES: rd = res_r;
			`EGC_OFF_ACC_CAP: rd = acc_r;
			`EGC_OFF_DEC_CAP: rd = dec_r;
			`EGC_OFF_SPD_CAP: rd = spd_r;
			`EGC_OFF_FERR_TH: rd = ferr_r;
			`EGC_OFF_POS_SPD: rd = pspd_r;
			`EGC_OFF_NEG_SPD: rd = nspd_r;
			`EGC_OFF_OVS_TH: rd = ovs_r;
			`EGC_OFF_BOUND_LO: rd = blo_r;
			`EGC_OFF_BOUND_HI: rd = bhi_r;
			`EGC_OFF_POS_CUR: rd = pcur_r;
			`EGC_OFF_NEG_CUR: rd = ncur_r;
			`EGC_OFF_CUR_REQ: rd = creq_r;
			`EGC_OFF_GEAR_POS: rd = gear_pos_r;
			`EGC_OFF_MOTOR_POS: rd = motor_pos_r;
			`EGC_OFF_POS_ERR: rd = err_r;
			`EGC_OFF_VEL: rd = vel_r;
			`EGC_OFF_STATUS: rd = {28'h0, status_r};
			`EGC_OFF_MASK: rd = {28'h0, mask_r};
			`EGC_OFF_WARN: rd = {20'h0, warn_r};
			`EGC_OFF_CUR_OUT: rd = current_command_o;
			default: rd = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_hit && mapped;
			wb_err_o <= wb_hit && !mapped;
			wb_dat_o <= (wb_hit && mapped && !wb_we_i) ? rd : 32'h0;
		end
	end
endmodule

// *** tb/egc_sva.sv ***
// Port checker for the gearing block.
`timescale 1ns/1ps
module egc_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [31:0] motor_reference_o,
	input wire logic motor_stop_o,
	input wire logic irq_o
);
	logic req;
	logic ok;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign ok = wb_adr_i <= 32'h5c && wb_adr_i[1:0] == 2'h0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_LAT: assert property (req && ok |=> wb_ack_o && !wb_err_o)
		else $error("No ack after a mapped request.");
	AST_ERR_MAP: assert property (req && !ok |=> wb_err_o && !wb_ack_o)
		else $error("No error after an unmapped request.");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(req && ok))
		else $error("Ack without a request.");
	AST_ONE_PULSE: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
		else $error("Answer longer than one cycle.");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("Read data outside ack.");
	AST_EXCL: assert property (!(wb_ack_o && wb_err_o))
		else $error("Ack and error together.");
	AST_RST_OUT: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !motor_stop_o
		&& motor_reference_o == 32'h0)
		else $error("Outputs not cleared by reset.");
	AST_STOP_HOLD: assert property (motor_stop_o && $past(motor_stop_o) && $past(motor_stop_o, 2)
		|-> $stable(motor_reference_o))
		else $error("Reference moves while stopped.");
	COV_ERR: cover property (wb_err_o);
	COV_IRQ: cover property ($rose(irq_o));
	COV_ACK: cover property (wb_ack_o ##2 wb_ack_o);
endmodule
bind egc_gearing egc_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .motor_reference_o(motor_reference_o),
	.motor_stop_o(motor_stop_o), .irq_o(irq_o));

// *** tb/egc_master.sv ***
// Behavioural pulse source standing in for the master controller.
`timescale 1ns/1ps
module egc_master (
	input wire logic clk_i,
	output egc_pkg::egc_pins_s pins_o
);
	logic [1:0] ph = 2'h0;
	initial pins_o = '0;
	task automatic gap(input int i);
		repeat (4 + i % 3) @(posedge clk_i);
	endtask
	// Sends n edges of the signalling chosen by md, negative when neg is set.
	task automatic move(input logic [3:0] md, input int n, input bit neg);
		for (int i = 0; i < n; i++) begin
			if (md == 4'h3) begin
				ph = neg ? ph - 2'h1 : ph + 2'h1;
				pins_o <= {ph[1] ^ ph[0], ph[1]};
			end else if (md == 4'h4) begin
				pins_o <= {1'b0, neg};
				gap(i);
				pins_o.src_a <= 1'b1;
				gap(i);
				pins_o.src_a <= 1'b0;
			end else begin
				pins_o <= neg ? 2'b01 : 2'b10;
				gap(i);
				pins_o <= 2'b00;
			end
			gap(i);
		end
	endtask
	task automatic idle();
		ph = 2'h0;
		pins_o <= '0;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// *** tb/electronic_gearing_command_tb.sv ***
// Self-checking bench for the gearing block.
`timescale 1ns/1ps
`include "egc_defs.svh"
module electronic_gearing_command_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] fb = 32'h0;
	logic [31:0] q;
	logic [31:0] rdat;
	logic [31:0] mref;
	logic signed [31:0] cur;
	logic e;
	logic ack;
	logic err;
	logic stop;
	logic irq;
	egc_pkg::egc_pins_s pins;
	int n_errors = 0;
	int tests_run = 0;
	int cyc_n = 0;
	int seed = 46;
	egc_gearing #(.UPDATE_CYC(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .port_pins_i(pins),
		.motor_feedback_i(fb), .motor_reference_o(mref), .current_command_o(cur),
		.motor_stop_o(stop), .irq_o(irq));
	egc_master m (.clk_i(clk_i), .pins_o(pins));
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Classic single cycle; ack and data are taken at the edge that shows ack.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		adr <= {24'h0, a};
		dat <= d;
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && err !== 1'b1 && t < 50);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (t >= 50) begin
			n_errors++;
			tally_and_finish();
		end
	endtask
	function automatic logic [31:0] gexp(input logic [31:0] b, input logic [3:0] md,
		input int n, input bit neg);
		if (md == 4'h2)
			return b;
		return b + 32'((neg ? -n : n) * 32'h1000_0000);
	endfunction
	function automatic logic [31:0] clampv(input int r, input int p, input int n);
		return r > p ? p : (r < -n ? -n : r);
	endfunction
	initial begin
		logic [31:0] base;
		int n;
		int p;
		int nn;
		int r;
		bit neg;
		logic [3:0] md;
		logic [3:0] mds [4] = '{4'h3, 4'h4, 4'h5, 4'h2};
		logic [7:0] ra [5] = '{`EGC_OFF_GEAR_NUM, `EGC_OFF_GEAR_DEN, `EGC_OFF_RES,
			`EGC_OFF_SPD_CAP, `EGC_OFF_BOUND_LO};
		logic [31:0] rv [5] = '{32'h1, 32'h1, `EGC_RST_RES, `EGC_RST_CAP, 32'h8000_0000};
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk(q, rv[i]);
		end
		bus(1'b0, 8'h64, 32'h0);
		chk({31'h0, e}, 32'h1);
		bus(1'b1, `EGC_OFF_CTRL, 32'h0321);
		m.move(4'h3, 6, 1'b0);
		repeat (20) @(posedge clk_i);
		chk(mref, 32'h0);
		m.idle();
		bus(1'b1, `EGC_OFF_RES, 32'h10);
		bus(1'b1, `EGC_OFF_GEAR_NUM, 32'h3);
		for (int k = 0; k < 4; k++) begin
			md = mds[k];
			n = (k == 0) ? 16 : 1 + {$random(seed)} % 20;
			neg = $random(seed);
			bus(1'b1, `EGC_OFF_CTRL, {19'h0, neg, md, 8'h22});
			bus(1'b0, `EGC_OFF_GEAR_POS, 32'h0);
			base = q;
			m.move(md, n, neg);
			repeat (8) @(posedge clk_i);
			bus(1'b0, `EGC_OFF_GEAR_POS, 32'h0);
			chk(q, gexp(base, md, n, neg));
			m.idle();
		end
		for (int k = 0; k < 6; k++) begin
			p = {$random(seed)} % 1000;
			nn = {$random(seed)} % 1000;
			r = (k == 0) ? p : $random(seed) % 1500;
			bus(1'b1, `EGC_OFF_POS_CUR, p);
			bus(1'b1, `EGC_OFF_NEG_CUR, nn);
			bus(1'b1, `EGC_OFF_CUR_REQ, r);
			repeat (2) @(posedge clk_i);
			chk(cur, clampv(r, p, nn));
		end
		bus(1'b1, `EGC_OFF_CTRL, 32'h0);
		bus(1'b1, `EGC_OFF_MASK, 32'h0);
		bus(1'b1, `EGC_OFF_FERR_TH, 32'h0);
		fb <= mref ^ 32'h4;
		repeat (4) @(posedge clk_i);
		bus(1'b0, `EGC_OFF_STATUS, 32'h0);
		chk({31'h0, q[0]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `EGC_OFF_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, `EGC_OFF_FERR_TH, 32'h7fff_ffff);
		bus(1'b1, `EGC_OFF_STATUS, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, `EGC_OFF_CTRL, 32'h0222);
		bus(1'b1, `EGC_OFF_BOUND_LO, 32'h7fff_0000);
		repeat (4) @(posedge clk_i);
		bus(1'b0, `EGC_OFF_WARN, 32'h0);
		chk(q, 32'h107);
		chk({31'h0, stop}, 32'h1);
		bus(1'b1, `EGC_OFF_BOUND_HI, 32'h8000_0001);
		repeat (2) @(posedge clk_i);
		bus(1'b0, `EGC_OFF_STATUS, 32'h0);
		chk({31'h0, q[3]}, 32'h1);
		tally_and_finish();
	end
endmodule
